/* logic/frs_pkg.sv */
// constants for the rate select, data byte port and diagnostic register slice
`default_nettype none
package frs_pkg;
  // register byte addresses on the avalon slave
  localparam logic [3:0] ADDR_RATE_SELECT = 4'h0;
  localparam logic [3:0] ADDR_DATA_PORT = 4'h4;
  localparam logic [3:0] ADDR_DIAG_INPUT = 4'h8;
  localparam logic [3:0] ADDR_MAIN_STATUS = 4'hC;
  localparam logic [4:0] ADDR_CONFIG_CTRL = 5'h10;
  // rate select fields
  localparam int RS_RESET_BIT = 7;
  localparam int RS_LOWPWR_BIT = 6;
  localparam int RS_SHIFT_LSB = 2;
  localparam logic [7:0] RS_RESET_VALUE = 8'h02;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [2:0] SHIFT_DEFAULT = 3'h0;
  localparam logic [2:0] SHIFT_NONE = 3'h7;
  localparam logic [2:0] SHIFT_41 = 3'h1;
  localparam logic [2:0] SHIFT_125 = 3'h3;
  // buffer
  localparam int BUF_DEPTH = 16;
  localparam logic [3:0] BUFFER_THRESHOLD_RESET = 4'h0;
  localparam logic [7:0] START_TRACK_RESET = 8'h00;
  // request gap in non-burst mode
  localparam int CLK_MHZ = 100;
  localparam int GAP_NS = 350;
  localparam int GAP_CYCLES = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SRST_CYCLES = 1;
  typedef enum logic [1:0] {FRS_BASELINE, FRS_ENHANCED, FRS_LEGACY} frs_mode_e;
  typedef enum logic [1:0] {FRS_CMD, FRS_EXEC, FRS_RESULT} frs_phase_e;
endpackage : frs_pkg
`default_nettype wire

/* logic/frs_regs.sv */
// rate select, data byte port with execution buffer, and diagnostic input register
`default_nettype none
module frs_regs
  import frs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] reg_mode,
  input wire logic disk_change_input,
  input wire logic dma_gate_flag,
  input wire logic [1:0] phase,
  input wire logic exec_is_write,
  input wire logic cfg_valid,
  input wire logic cfg_buf_enable,
  input wire logic [3:0] cfg_threshold,
  input wire logic [7:0] cfg_start_track,
  input wire logic cfg_lock,
  input wire logic mode_valid,
  input wire logic mode_burst,
  input wire logic mode_rd_disable,
  input wire logic mode_wr_disable,
  input wire logic mode_low_power,
  input wire logic [7:0] disk_byte_in,
  input wire logic disk_byte_in_valid,
  input wire logic disk_byte_out_ready,
  output logic [7:0] disk_byte_out,
  output logic disk_byte_out_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_byte_valid,
  output logic result_byte_ready,
  input wire logic [7:0] result_byte,
  output logic soft_reset,
  output logic low_power,
  output logic [1:0] data_rate,
  output logic [2:0] write_shift_sel,
  output logic [7:0] shift_start_track,
  output logic no_shift_flag,
  output logic [3:0] buffer_threshold,
  output logic xfer_request
);
  // ===========================================================
  // address map, low byte lane only
  //   0x00 rate select control, write only
  //   0x04 data byte port, read and write
  //   0x08 diagnostic input status, read only
  //   0x0C main status touch, reads zero, wakes from low power
  //   0x10 configuration control, write only
  // every other address reads zero and ignores writes
  //
  // bus timing
  //   the slave answers every request on its second edge
  //   waitrequest idles high, so a request is never taken on the
  //   edge that first shows it; this keeps the decode registered
  //   and costs one wait state per access
  //
  // reset
  //   hard reset loads every register except the buffer memory to its documented value
  //   soft reset is a one cycle pulse from rate select bit 7;
  //   it clears the mode state and, unless locked, the configure state, but leaves rate, shift code,
  //   no-shift flag and the diagnostic path untouched
  //
  // limitation
  //   the change pin is only synchronised, not filtered;
  //   software must ignore the change bit while powered down
  // ===========================================================
  // bus decode
  logic [7:0] rate_select_control;
  logic wr_rs, wr_cc, acc_data, acc_stat, rd_data, wr_data;
  logic [7:0] wdat;
  logic [1:0] chg_sync;
  logic chg;
  logic in_exec, buf_on;
  logic [7:0] mem [BUF_DEPTH];
  logic [4:0] count;
  logic [3:0] rd_ptr, wr_ptr;
  logic [$clog2(GAP_CYCLES+1)-1:0] gap;
  logic burst, rd_dis, wr_dis, lock, buf_en;
  assign wdat = avs_writedata[7:0];
  // full address compare, so config control never aliases onto rate select
  assign wr_rs = avs_write
                 && avs_waitrequest == 1'b0
                 && avs_address == {1'b0, ADDR_RATE_SELECT};
  assign wr_cc = avs_write
                 && !avs_waitrequest
                 && avs_address == ADDR_CONFIG_CTRL;
  assign acc_data = (avs_read || avs_write)
                    && !avs_waitrequest
                    && avs_address == {1'b0, ADDR_DATA_PORT};
  // any access to main status wakes, a write as well as a read
  assign acc_stat = (avs_read || avs_write)
                    && !avs_waitrequest
                    && avs_address == {1'b0, ADDR_MAIN_STATUS};
  assign rd_data = acc_data && avs_read;
  assign wr_data = acc_data && avs_write;
  assign in_exec = phase == 2'(FRS_EXEC);
  // ===========================================================
  // avalon handshake: one wait cycle, answer on the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
  // ===========================================================
  // rate select and config control
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_select_control <= RS_RESET_VALUE;
      data_rate <= RATE_RESET;
      no_shift_flag <= 1'b0;
    end else if (wr_rs) begin
      rate_select_control <= {1'b0, wdat[6], 1'b0, wdat[4:0]};
      data_rate <= wdat[1:0];
    end else if (wr_cc) begin
      data_rate <= wdat[1:0];
      no_shift_flag <= wdat[2];
    end
  end
  // soft reset pulse; it touches neither rate nor shift code, but it clears low power
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wr_rs && wdat[RS_RESET_BIT];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_power <= 1'b0;
    end else if (soft_reset || acc_data || acc_stat) begin
      low_power <= 1'b0;
    end else if ((wr_rs && wdat[RS_LOWPWR_BIT]) || (mode_valid && mode_low_power)) begin
      low_power <= 1'b1;
    end
  end
  // ===========================================================
  // write shift selection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_shift_sel <= SHIFT_125;
    end else if (rate_select_control[4:2] != SHIFT_DEFAULT) begin
      write_shift_sel <= rate_select_control[4:2];
    end else begin
      write_shift_sel <= (data_rate == RATE_1M) ? SHIFT_41 : SHIFT_125;
    end
  end
  // ===========================================================
  // configure and mode command state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_en <= 1'b0;
      buffer_threshold <= BUFFER_THRESHOLD_RESET;
      shift_start_track <= START_TRACK_RESET;
      lock <= 1'b0;
    end else if (cfg_valid) begin
      buf_en <= cfg_buf_enable;
      buffer_threshold <= cfg_buf_enable ? cfg_threshold : BUFFER_THRESHOLD_RESET;
      shift_start_track <= cfg_start_track;
      lock <= cfg_lock;
    end else if (soft_reset && !lock) begin
      buf_en <= 1'b0;
      buffer_threshold <= BUFFER_THRESHOLD_RESET;
      shift_start_track <= START_TRACK_RESET;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst <= 1'b0;
      rd_dis <= 1'b0;
      wr_dis <= 1'b0;
    end else if (mode_valid) begin
      burst <= mode_burst;
      rd_dis <= mode_rd_disable;
      wr_dis <= mode_wr_disable;
    end else if (soft_reset) begin
      burst <= 1'b0;
      rd_dis <= 1'b0;
      wr_dis <= 1'b0;
    end
  end
  assign buf_on = buf_en && in_exec && !(exec_is_write ? wr_dis : rd_dis);
  // ===========================================================
  // execution buffer; depth one when bypassed
  logic push, pop;
  logic [4:0] cap;
  assign cap = buf_on ? 5'(BUF_DEPTH) : 5'd1;
  assign push = exec_is_write ? wr_data : disk_byte_in_valid;
  assign pop = exec_is_write ? (disk_byte_out_ready && disk_byte_out_valid) : rd_data;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 5'd0;
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else if (soft_reset || !in_exec) begin
      count <= 5'd0;
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else begin
      if (push && count < cap) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop && count != 5'd0) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      count <= count + 5'(push && count < cap) - 5'(pop && count != 5'd0);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (in_exec && push && count < cap) begin
      mem[wr_ptr] <= exec_is_write ? wdat : disk_byte_in;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      disk_byte_out <= 8'h00;
      disk_byte_out_valid <= 1'b0;
    end else begin
      disk_byte_out <= mem[rd_ptr];
      disk_byte_out_valid <= in_exec && exec_is_write && count != 5'd0 && !pop;
    end
  end
  // ===========================================================
  // transfer request with non-burst gap
  logic want;
  assign want = exec_is_write ? (count < cap) : (count != 5'd0);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
      xfer_request <= 1'b0;
    end else begin
      if (acc_data && !burst) begin
        gap <= ($bits(gap))'(GAP_CYCLES);
      end else if (gap != '0) begin
        gap <= gap - 1'b1;
      end
      // burst holds the line while bytes remain to read or room remains to write, dropping only on an access cycle
      xfer_request <= in_exec && want && !acc_data && (burst || gap == '0);
    end
  end
  // ===========================================================
  // command and result bytes bypass the buffer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte <= 8'h00;
      cmd_byte_valid <= 1'b0;
      result_byte_ready <= 1'b0;
    end else begin
      cmd_byte <= wdat;
      cmd_byte_valid <= wr_data && phase == 2'(FRS_CMD);
      result_byte_ready <= rd_data && phase == 2'(FRS_RESULT);
    end
  end
  // ===========================================================
  // diagnostic register, read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chg_sync <= 2'b00;
    end else begin
      chg_sync <= {chg_sync[0], disk_change_input};
    end
  end
  // while powered down the change bit is meaningless to software
  assign chg = chg_sync[1];
  // dense flag: low at the two fast rates (11, 00), high at the slow ones
  logic dense_rate_flag;
  assign dense_rate_flag = ^data_rate;
  logic [7:0] diag;
  always_comb begin
    unique case (reg_mode)
      2'(FRS_ENHANCED): begin
        diag = {chg, 4'hF, data_rate, dense_rate_flag};
      end
      2'(FRS_LEGACY): diag = {!chg, 3'h0, dma_gate_flag, no_shift_flag, data_rate};
      default: diag = {chg, 7'h00}; // low bits undriven, read as zero
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      if (avs_address == {1'b0, ADDR_DIAG_INPUT}) begin
        avs_readdata <= {24'h0, diag};
      end else if (avs_address == {1'b0, ADDR_DATA_PORT}) begin
        avs_readdata <= {24'h0, in_exec ? mem[rd_ptr] : result_byte};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end
endmodule // frs_regs
`default_nettype wire

/* verif/frs_host.sv */
// host processor model: avalon master for the register slice
`default_nettype none
module frs_host (
  input wire logic clk_sys,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // bus cycle
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // held until waitrequest is seen low; only the bench watchdog ends a hang
  // every byte waits on its own answer before the next one
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // frs_host
`default_nettype wire

/* verif/frs_regs_properties.sv */
// port assertions for the register slice
`default_nettype none
module frs_regs_properties
  import frs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] reg_mode,
  input wire logic soft_reset,
  input wire logic low_power,
  input wire logic [1:0] data_rate,
  input wire logic no_shift_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd_q;
  logic dn, rs_wr, rate_wr, dg_rd, wake;
  assign dn = (avs_read || avs_write) && !avs_waitrequest;
  assign rs_wr = dn && avs_write && avs_address == 5'(ADDR_RATE_SELECT);
  assign rate_wr = rs_wr || (dn && avs_write && avs_address == 5'h10);
  assign dg_rd = dn && avs_read && avs_address == 5'(ADDR_DIAG_INPUT);
  assign wake = dn && avs_address inside {5'(ADDR_DATA_PORT), 5'(ADDR_MAIN_STATUS)};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wd_q <= 8'h00;
    else wd_q <= avs_writedata[7:0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // relations
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_srst_start: assert property (rs_wr && avs_writedata[7] |=> soft_reset)
    else $error("soft reset missing");
  a_srst_clear: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset stuck");
  a_rate_kept: assert property (soft_reset |=> $stable(data_rate))
    else $error("rate lost on soft reset");
  a_rate_write: assert property (rate_wr |=> data_rate == wd_q[1:0])
    else $error("rate not from last write");
  a_power_enter: assert property (rs_wr && avs_writedata[6] && !avs_writedata[7] |=> low_power)
    else $error("low power not entered");
  a_power_wake: assert property (wake |=> !low_power)
    else $error("low power not left");
  a_diag_enh: assert property (dg_rd && reg_mode == FRS_ENHANCED |->
    avs_readdata[6:0] == {4'hF, data_rate, ^data_rate}) else $error("enhanced diag");
  a_diag_leg: assert property (dg_rd && reg_mode == FRS_LEGACY |->
    avs_readdata[6:4] == 3'h0 && avs_readdata[2:0] == {no_shift_flag, data_rate})
    else $error("legacy diag");
  c_srst: cover property (soft_reset);
  c_wake: cover property (low_power ##1 !low_power);
  c_leg: cover property (dg_rd && reg_mode == FRS_LEGACY);
endmodule // frs_regs_properties
bind frs_regs frs_regs_properties u_props (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .reg_mode, .soft_reset, .low_power,
  .data_rate, .no_shift_flag);
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the register slice
`default_nettype none
module tb
  import frs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dc = 1'b1;
  logic cfg_valid = 1'b0;
  logic cfg_lock = 1'b0;
  logic mode_valid = 1'b0;
  logic [1:0] reg_mode = 2'h0;
  logic [1:0] phase = 2'h0;
  logic [7:0] result_byte = 8'hC3;
  logic [7:0] q, cmd_seen, cmd_byte, shift_start_track;
  logic [31:0] avs_writedata, avs_readdata;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, soft_reset, low_power, no_shift_flag, cmd_byte_valid;
  logic [1:0] data_rate;
  logic [2:0] write_shift_sel;
  logic [3:0] buffer_threshold;
  int num_errors = 0;
  int tests_run = 0;
  int pulses = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (soft_reset === 1'b1) pulses <= pulses + 1;
    if (cmd_byte_valid === 1'b1) cmd_seen <= cmd_byte;
  end
  frs_host host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
    .avs_writedata);
  frs_regs uut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .reg_mode, .disk_change_input(dc), .dma_gate_flag(dc),
    .phase, .exec_is_write(phase[1]), .cfg_valid, .cfg_buf_enable(cfg_lock),
    .cfg_threshold(4'h5), .cfg_start_track(8'h07), .cfg_lock, .mode_valid,
    .mode_burst(cfg_lock), .mode_rd_disable(dc), .mode_wr_disable(dc),
    .mode_low_power(mode_valid), .disk_byte_in(result_byte), .disk_byte_in_valid(1'b0),
    .disk_byte_out_ready(1'b1), .disk_byte_out(), .disk_byte_out_valid(), .cmd_byte,
    .cmd_byte_valid, .result_byte_ready(), .result_byte, .soft_reset, .low_power, .data_rate,
    .write_shift_sel, .shift_start_track, .no_shift_flag, .buffer_threshold, .xfer_request());
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
    @(posedge clk_sys);
    // look once the registered outputs have settled
    @(negedge clk_sys);
  endtask
  task automatic hard_reset(input logic [1:0] m);
    rst_n <= 1'b0;
    reg_mode <= m;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  task automatic cfg(input logic lk);
    @(posedge clk_sys);
    cfg_lock <= lk;
    cfg_valid <= 1'b1;
    @(posedge clk_sys);
    cfg_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_rates();
    chk("rate", 8'(data_rate), 8'h02);
    for (int r = 0; r < 4; r++) begin
      wr(5'(ADDR_RATE_SELECT), 8'(32 + r));
      chk("rate", 8'(data_rate), 8'(r));
      chk("shift", 8'(write_shift_sel), 8'(r == 3 ? SHIFT_41 : SHIFT_125));
    end
    for (int c = 1; c < 8; c++) begin
      wr(5'(ADDR_RATE_SELECT), 8'(c * 4));
      chk("shift", 8'(write_shift_sel), 8'(c));
    end
    wr(5'h10, 8'h03);
    chk("rate", 8'(data_rate), 8'h03);
    host.xfer(1'b0, 5'h14, 8'h00, q);
    chk("unmapped", q, 8'h00);
  endtask
  task automatic t_srst();
    cfg(1'b0);
    chk("buffer_threshold", 8'(buffer_threshold), 8'h00);
    cfg(1'b1);
    chk("buffer_threshold", 8'(buffer_threshold), 8'h05);
    chk("track", shift_start_track, 8'h07);
    wr(5'(ADDR_RATE_SELECT), 8'h81);
    wr(5'(ADDR_RATE_SELECT), 8'h01);
    chk("pulses", 8'(pulses), 8'h01);
    chk("rate", 8'(data_rate), 8'h01);
    chk("buffer_threshold", 8'(buffer_threshold), 8'h05);
    hard_reset(2'h0);
    chk("buffer_threshold", 8'(buffer_threshold), 8'h00);
  endtask
  task automatic t_power();
    wr(5'(ADDR_RATE_SELECT), 8'h42);
    chk("lowpwr", 8'(low_power), 8'h01);
    host.xfer(1'b0, 5'(ADDR_MAIN_STATUS), 8'h00, q);
    @(posedge clk_sys);
    chk("lowpwr", 8'(low_power), 8'h00);
    mode_valid <= 1'b1;
    @(posedge clk_sys);
    mode_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("lowpwr", 8'(low_power), 8'h01);
    wr(5'(ADDR_RATE_SELECT), 8'hC2);
    chk("lowpwr", 8'(low_power), 8'h00);
    wr(5'(ADDR_DATA_PORT), 8'h5A);
    @(posedge clk_sys);
    chk("cmd", cmd_seen, 8'h5A);
    phase <= 2'(FRS_RESULT);
    host.xfer(1'b0, 5'(ADDR_DATA_PORT), 8'h00, q);
    chk("result", q, 8'hC3);
  endtask
  task automatic t_diag();
    logic [7:0] exp [6] = '{8'h00, 8'h80, 8'h7B, 8'hFB, 8'h85, 8'h0D};
    for (int i = 0; i < 6; i++) begin
      dc <= i[0];
      hard_reset(2'(i / 2));
      wr(5'h10, 8'h05);
      // disk change passes a two-flop synchroniser
      repeat (3) @(posedge clk_sys);
      host.xfer(1'b0, 5'(ADDR_DIAG_INPUT), 8'h00, q);
      chk("diag", q, exp[i]);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    hard_reset(2'h0);
    t_rates();
    t_srst();
    t_power();
    t_diag();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
